// ===== lpcd_pkg.sv
// lpcd_pkg: constants and carrier types of the low-power command decoder.
// assumes CA pins already sampled onto mclk by the decoder front end.
package lpcd_pkg;
    localparam int CA_W = 10;
    localparam int BUSY_W = 8;
    localparam int EXIT_CYC = 2;
    localparam logic [BUSY_W-1:0] OP_BUSY_CYC = 8'h08;
    localparam logic [3:0] OPC_MRW = 4'h0;
    localparam logic [3:0] OPC_MRR = 4'h8;
    localparam logic [3:0] OPC_REFRESH_ONE_BANK_CMD = 4'h4;
    localparam logic [3:0] OPC_REFRESH_ALL_BANKS_CMD = 4'hc;
    localparam logic [2:0] OPC_DPD = 3'h3;
    localparam logic [2:0] OPC_NOP = 3'h7;

    typedef enum logic [3:0] {
        LPCD_CMD_NONE, LPCD_CMD_NOP, LPCD_CMD_MRW, LPCD_CMD_MRR, LPCD_CMD_REFRESH_ONE_BANK_CMD,
        LPCD_CMD_REFRESH_ALL_BANKS_CMD, LPCD_CMD_ACT, LPCD_CMD_WR, LPCD_CMD_RD, LPCD_CMD_PRE,
        LPCD_CMD_BST, LPCD_CMD_DPD, LPCD_CMD_PD, LPCD_CMD_SREF, LPCD_CMD_ILL
    } lpcd_cmd_t;

    typedef enum logic [2:0] {
        LPCD_POWER_ON, LPCD_ACTIVE, LPCD_POWER_DOWN, LPCD_SELF_REF, LPCD_DEEP_SLEEP
    } lpcd_state_t;

    // pins after synchronisation; ca_f holds the falling-edge half
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [CA_W-1:0] ca_r;
        logic [CA_W-1:0] ca_f;
    } lpcd_pins_t;

    // decoded command with its fields
    typedef struct packed {
        logic valid;
        lpcd_cmd_t cmd;
        logic [2:0] bank;
        logic [14:0] row;
        logic [11:0] col;
        logic [7:0] mr_addr;
        logic [7:0] mr_op;
        logic auto_pre;
    } lpcd_out_t;
endpackage

// ===== lpcd_sync.sv
// lpcd_sync: two-flop synchroniser for a group of pin inputs.
// assumes the pins are asynchronous to mclk.
module lpcd_sync
    import lpcd_pkg::*;
#(
    parameter int W = 22
)(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (W < 1)
    begin : g_bad_width
        $error("lpcd_sync: width must be positive");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lpcd_sync_st_t;

    lpcd_sync_st_t st_q, st_d;

    always_comb
    begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // cke idles low at reset so nothing decodes before the bus settles
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule

// ===== lpcd_decode.sv
// lpcd_decode: command decoder and sleep state tracker of a low-power dram.
// assumes pins are sampled into mclk; ca_f_pin is captured by the pad on the falling edge.
module lpcd_decode
    import lpcd_pkg::*;
#(
    parameter int BUSY_CYCLES = 8
)(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // command pins
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic [CA_W-1:0] ca_r_pin,
    input wire logic [CA_W-1:0] ca_f_pin,
    // initialisation done from the init sequencer
    input wire logic init_done,
    // decoded command
    output lpcd_out_t cmd_out,
    // state and power controls
    output lpcd_state_t dev_state,
    output logic ready,
    output logic low_current,
    output logic buffers_enable,
    output logic core_power_enable,
    output logic array_invalid,
    output logic illegal_event
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    // busy counter is BUSY_W bits wide
    if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255)
    begin : g_bad_busy
        $error("lpcd_decode: BUSY_CYCLES out of range");
    end

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    lpcd_pins_t pins;
    logic [2*CA_W+1:0] sync_out;

    lpcd_sync #(.W(2*CA_W+2)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({cke_pin, cs_n_pin, ca_r_pin, ca_f_pin}),
        .dout(sync_out)
    );
    assign pins = sync_out;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        lpcd_state_t state;
        logic cke_prev;
        logic [BUSY_W-1:0] busy;
        logic [1:0] exit_cnt;
        logic arr_inv;
        logic ill;
        lpcd_out_t out;
    } lpcd_st_t;

    lpcd_st_t st_q, st_d;

    // ----------------------------------------
    // command decode
    // ----------------------------------------

    function automatic lpcd_cmd_t decode(input logic cke_p, input logic cke_n, input logic cs_n,
                                         input logic [3:0] op);
        lpcd_cmd_t c;
        c = LPCD_CMD_ILL;
        if (cke_p && cs_n)
            c = cke_n ? LPCD_CMD_NOP : LPCD_CMD_PD;
        else if (cke_p && !cke_n)
        begin
            // only deep sleep and self refresh may drop cke with cs low
            if (op[2:0] == OPC_DPD)
                c = LPCD_CMD_DPD;
            else if (op[2:0] == 3'h4)
                c = LPCD_CMD_SREF;
        end
        else if (!cke_p)
            c = LPCD_CMD_NONE;
        else if (op[2:0] == OPC_NOP) c = LPCD_CMD_NOP;
        else if (op == OPC_MRW) c = LPCD_CMD_MRW;
        else if (op == OPC_MRR) c = LPCD_CMD_MRR;
        else if (op == OPC_REFRESH_ONE_BANK_CMD) c = LPCD_CMD_REFRESH_ONE_BANK_CMD;
        else if (op == OPC_REFRESH_ALL_BANKS_CMD) c = LPCD_CMD_REFRESH_ALL_BANKS_CMD;
        else if (op[1:0] == 2'h2) c = LPCD_CMD_ACT;
        else if (op[2:0] == 3'h1) c = LPCD_CMD_WR;
        else if (op[2:0] == 3'h5) c = LPCD_CMD_RD;
        else if (op == 4'hb) c = LPCD_CMD_PRE;
        else if (op == 4'h3) c = LPCD_CMD_BST;
        return c;
    endfunction

    lpcd_cmd_t cmd_now;
    // ca0..ca3 on the rising half, cs and cke at the rising edge
    assign cmd_now = decode(st_q.cke_prev, pins.cke, pins.cs_n,
                            {pins.ca_r[3], pins.ca_r[2], pins.ca_r[1], pins.ca_r[0]});

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.cke_prev = pins.cke;
        st_d.out.valid = 1'b0;
        st_d.ill = 1'b0;
        if (st_q.busy != '0)
            st_d.busy = st_q.busy - 1'b1;
        unique case (st_q.state)
            LPCD_POWER_ON:
            begin
                // only reinitialisation brings the device back
                if (init_done && pins.cke)
                begin
                    st_d.state = LPCD_ACTIVE;
                    st_d.exit_cnt = 2'(EXIT_CYC);
                end
            end
            LPCD_ACTIVE:
            begin
                if (st_q.exit_cnt != 2'h0)
                    st_d.exit_cnt = st_q.exit_cnt - 2'h1;
                unique case (cmd_now)
                    LPCD_CMD_DPD:
                    begin
                        st_d.state = LPCD_DEEP_SLEEP;
                        st_d.arr_inv = 1'b1;
                    end
                    LPCD_CMD_PD: st_d.state = LPCD_POWER_DOWN;
                    LPCD_CMD_SREF: st_d.state = LPCD_SELF_REF;
                    LPCD_CMD_NOP, LPCD_CMD_NONE: ;
                    LPCD_CMD_ILL: st_d.ill = 1'b1;
                    default:
                    begin
                        // ca_r[9:2] and the falling half give the remaining fields
                        st_d.out.valid = (st_q.exit_cnt == 2'h0);
                        st_d.out.cmd = cmd_now;
                        st_d.out.bank = pins.ca_r[9:7];
                        st_d.out.row = {pins.ca_f[9:8], pins.ca_r[6:2], pins.ca_f[7:0]};
                        st_d.out.col = {pins.ca_f[9:1], pins.ca_r[6:5], 1'b0};
                        st_d.out.auto_pre = pins.ca_f[0];
                        st_d.out.mr_addr = {pins.ca_f[1:0], pins.ca_r[9:4]};
                        st_d.out.mr_op = pins.ca_f[9:2];
                        if (cmd_now inside {LPCD_CMD_ACT, LPCD_CMD_PRE, LPCD_CMD_REFRESH_ONE_BANK_CMD, LPCD_CMD_REFRESH_ALL_BANKS_CMD})
                            st_d.busy = BUSY_W'(BUSY_CYCLES);
                    end
                endcase
            end
            LPCD_POWER_DOWN, LPCD_SELF_REF:
            begin
                if (pins.cke && pins.cs_n)
                begin
                    st_d.state = LPCD_ACTIVE;
                    st_d.exit_cnt = 2'(EXIT_CYC);
                end
            end
            LPCD_DEEP_SLEEP:
            begin
                if (pins.cke)
                    st_d.state = LPCD_POWER_ON;
            end
        endcase
        if (st_q.state == LPCD_POWER_ON && init_done)
            st_d.arr_inv = 1'b0;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.state <= LPCD_POWER_ON;
            st_q.arr_inv <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cmd_out = st_q.out;
    assign dev_state = st_q.state;
    assign ready = (st_q.state == LPCD_ACTIVE) && (st_q.exit_cnt == 2'h0);
    // lowest current only once running operations finish
    assign low_current = (st_q.state != LPCD_ACTIVE) && (st_q.state != LPCD_POWER_ON) && (st_q.busy == '0);
    assign buffers_enable = (st_q.state != LPCD_DEEP_SLEEP);
    assign core_power_enable = (st_q.state != LPCD_DEEP_SLEEP) || (st_q.busy != '0);
    assign array_invalid = st_q.arr_inv;
    assign illegal_event = st_q.ill;
endmodule

// ===== lpcd_monitor.sv
// lpcd_monitor: port checks for lpcd_decode.
// assumes pins reach cmd_out three rising edges after they are sampled.
module lpcd_monitor
    import lpcd_pkg::*;
#(
    parameter int BUSY_CYCLES = 8
)(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // pins
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic [CA_W-1:0] ca_r_pin,
    input wire logic init_done,
    // results
    input wire lpcd_out_t cmd_out,
    input wire lpcd_state_t dev_state,
    input wire logic ready,
    input wire logic low_current,
    input wire logic buffers_enable,
    input wire logic core_power_enable,
    input wire logic array_invalid,
    input wire logic illegal_event
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ------------------------------
    // assertions
    // ------------------------------
    property p_enter;
        $past(cke_pin) && !cke_pin && !cs_n_pin && ca_r_pin[2:0] == 3'h3 && dev_state == LPCD_ACTIVE
            |-> ##[2:4] dev_state == LPCD_DEEP_SLEEP;
    endproperty
    a_enter: assert property (p_enter) else $error("deep sleep not entered");
    property p_lost;
        dev_state == LPCD_DEEP_SLEEP |-> array_invalid;
    endproperty
    a_lost: assert property (p_lost) else $error("array not marked lost");
    property p_off;
        dev_state == LPCD_DEEP_SLEEP |-> !buffers_enable && (core_power_enable == !low_current);
    endproperty
    a_off: assert property (p_off) else $error("sleep left power on");
    property p_wake;
        dev_state == LPCD_DEEP_SLEEP && $rose(cke_pin) |-> ##[2:4] dev_state == LPCD_POWER_ON;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not to power-on");
    property p_noinit;
        dev_state == LPCD_POWER_ON && !init_done |-> !ready;
    endproperty
    a_noinit: assert property (p_noinit) else $error("ready before init");
    property p_nop;
        cke_pin && $past(cke_pin) && (cs_n_pin || ca_r_pin[2:0] == 3'h7)
            |-> ##3 !cmd_out.valid || cmd_out.cmd == LPCD_CMD_NOP;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op decoded as command");
    property p_act;
        cke_pin && $past(cke_pin) && !cs_n_pin && ca_r_pin[1:0] == 2'h2 && ready
            |-> ##3 cmd_out.valid && cmd_out.cmd == LPCD_CMD_ACT;
    endproperty
    a_act: assert property (p_act) else $error("activate not decoded");
    property p_col;
        cmd_out.valid && cmd_out.cmd inside {LPCD_CMD_RD, LPCD_CMD_WR} |-> cmd_out.col[0] == 1'b0;
    endproperty
    a_col: assert property (p_col) else $error("column bit zero set");
    property p_busy;
        cmd_out.valid && cmd_out.cmd == LPCD_CMD_ACT |=> !low_current [*6];
    endproperty
    a_busy: assert property (p_busy) else $error("low current too early");
    property p_ill;
        $past(cke_pin) && !cke_pin && !cs_n_pin && ca_r_pin[2:0] == 3'h0 && dev_state == LPCD_ACTIVE
            |-> ##3 illegal_event;
    endproperty
    a_ill: assert property (p_ill) else $error("illegal entry not flagged");
endmodule

bind lpcd_decode lpcd_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) u_mon (.mclk, .sys_rst, .cke_pin, .cs_n_pin,
    .ca_r_pin, .init_done, .cmd_out, .dev_state, .ready, .low_current, .buffers_enable,
    .core_power_enable, .array_invalid, .illegal_event);

// ===== lpcd_host.sv
// lpcd_host: behavioural controller driving the command pins.
// assumes a free-running mclk; pins move 1 ns after a rising edge.
module lpcd_host
    import lpcd_pkg::*;
(
    // clock
    input wire logic mclk,
    // command pins
    output logic cke_pin,
    output logic cs_n_pin,
    output logic [CA_W-1:0] ca_r_pin,
    output logic [CA_W-1:0] ca_f_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cke_pin = 1'b1;
        cs_n_pin = 1'b1;
        ca_r_pin = '0;
        ca_f_pin = '0;
    end
    // one command, held across exactly one sampling edge
    task automatic send(input logic cke, input logic cs_n, input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
        @(posedge mclk);
        #1;
        cke_pin = cke;
        cs_n_pin = cs_n;
        ca_r_pin = r;
        ca_f_pin = f;
    endtask
    // cke edge with cs high: power-down entry or exit, deep sleep wake
    task automatic flip_cke;
        @(posedge mclk);
        #1;
        cke_pin = ~cke_pin;
        cs_n_pin = 1'b1;
    endtask
    // cke drop with cs low; r carries the entry opcode
    task automatic enter_low(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
        @(posedge mclk);
        #1;
        cke_pin = 1'b0;
        cs_n_pin = 1'b0;
        ca_r_pin = r;
        ca_f_pin = f;
    endtask
    // deselect keeps cke level; ca toggles so stale values never look valid
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            cs_n_pin = 1'b1;
            ca_r_pin = ~ca_r_pin;
            ca_f_pin = ~ca_f_pin;
        end
    endtask
endmodule

// ===== lpcd_decode_tb.sv
// lpcd_decode_tb: self-checking bench for lpcd_decode.
// assumes lpcd_pkg, lpcd_sync, lpcd_monitor and lpcd_host compile first.
module lpcd_decode_tb
    import lpcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, sys_rst, init_done, cke_pin, cs_n_pin, ready, low_current;
    logic buffers_enable, core_power_enable, array_invalid, illegal_event;
    logic [CA_W-1:0] ca_r_pin, ca_f_pin;
    lpcd_out_t cmd_out;
    lpcd_state_t dev_state;
    int bad_count, tests_run;
    int ill_seen;
    logic [31:0] seed_q = 32'hb944e111;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic w_got;
    lpcd_cmd_t cmd_tab[9] = '{LPCD_CMD_MRW, LPCD_CMD_MRR, LPCD_CMD_REFRESH_ONE_BANK_CMD, LPCD_CMD_REFRESH_ALL_BANKS_CMD, LPCD_CMD_ACT,
        LPCD_CMD_WR, LPCD_CMD_RD, LPCD_CMD_PRE, LPCD_CMD_BST};
    // upper nibble masks the fixed opcode bits, lower nibble gives them
    logic [7:0] op_tab[9] = '{8'hf0, 8'hf8, 8'hf4, 8'hfc, 8'h32, 8'h71, 8'h75, 8'hfb, 8'hf3};

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    lpcd_host u_host (.mclk, .cke_pin, .cs_n_pin, .ca_r_pin, .ca_f_pin);
    lpcd_decode #(.BUSY_CYCLES(8)) u_dut (.mclk, .sys_rst, .cke_pin, .cs_n_pin, .ca_r_pin, .ca_f_pin,
        .init_done, .cmd_out, .dev_state, .ready, .low_current, .buffers_enable, .core_power_enable,
        .array_invalid, .illegal_event);

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_cmd(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t cmd got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(input logic [5:0] exp);
        tests_run++;
        if ({dev_state, ready, buffers_enable, core_power_enable} !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t state exp %h", $time, exp);
        end
    endtask
    task automatic issue(input int i);
        logic [CA_W-1:0] r, f;
        logic w;
        seed_q = lfsr_next(seed_q);
        r = (seed_q[9:0] & ~{6'h0, op_tab[i][7:4]}) | {6'h0, op_tab[i][3:0]};
        f = seed_q[25:16];
        w = i == 5 || i == 6;
        exp_q.push_back({cmd_tab[i], w, {f[9:1], r[6:5], 1'b0} & {12{w}}});
        u_host.send(1'b1, 1'b0, r, f);
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // oldest note against each decoded command
    // sampled mid-cycle, where the registered outputs have settled
    always @(negedge mclk)
        if (cmd_out.valid && cmd_out.cmd inside {[LPCD_CMD_MRW:LPCD_CMD_BST]})
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff;
            w_got = cmd_out.cmd inside {LPCD_CMD_WR, LPCD_CMD_RD};
            chk_cmd({cmd_out.cmd, w_got, cmd_out.col & {12{w_got}}}, e);
        end

    always @(negedge mclk)
        if (illegal_event)
            ill_seen++;

    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        sys_rst = 1'b1;
        init_done = 1'b0;
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'b0;
        u_host.idle(4);
        init_done = 1'b1;
        u_host.idle(6);
        for (int k = 0; k < 18; k++)
            issue(k % 9);
        u_host.send(1'b1, seed_q[10], {seed_q[9:3], 3'h7}, seed_q[19:10]);
        issue(6);
        u_host.idle(8);
        issue(4);
        u_host.flip_cke();
        u_host.idle(12);
        u_host.flip_cke();
        u_host.idle(8);
        issue(0);
        u_host.idle(4);
        issue(4);
        // deep sleep while the activate still runs: core power must wait for it
        u_host.enter_low({seed_q[9:3], 3'h3}, seed_q[19:10]);
        init_done = 1'b0;
        u_host.idle(12);
        chk_lvl({LPCD_DEEP_SLEEP, 3'b000});
        u_host.flip_cke();
        u_host.idle(6);
        chk_lvl({LPCD_POWER_ON, 3'b011});
        init_done = 1'b1;
        u_host.idle(6);
        chk_lvl({LPCD_ACTIVE, 3'b111});
        issue(6);
        issue(5);
        u_host.idle(8);
        u_host.enter_low({seed_q[9:3], 3'h0}, seed_q[19:10]);
        u_host.flip_cke();
        u_host.idle(6);
        chk_cmd(17'(exp_q.size()), 17'h0);
        chk_cmd(17'(ill_seen), 17'h1);
        tally_and_finish();
    end
endmodule
